// [common/tcu_defs.svh]
// Offsets, field positions, reset values and counts of the capture unit
`ifndef TCU_DEFS_SVH
`define TCU_DEFS_SVH
`define TCU_OFF_CTRL      12'h000
`define TCU_OFF_CAPT_LO   12'h004
`define TCU_OFF_CAPT_HI   12'h008
`define TCU_OFF_TB_LO     12'h00c
`define TCU_OFF_TB_HI     12'h010
`define TCU_OFF_TB_CTRL   12'h014
`define TCU_OFF_STATUS    12'h018
`define TCU_OFF_IRQ_EN    12'h01c
`define TCU_OFF_IRQ_CLR   12'h020
`define TCU_OFF_GLOBAL    12'h024
`define TCU_CTRL_RESET    8'h00
`define TCU_TB_CTRL_RESET 8'h00
`define TCU_MODE_MSB      3
`define TCU_MODE_LSB      0
`define TCU_TB_ON_BIT     0
`define TCU_TB_SRC_BIT    1
`define TCU_ST_CAPT_BIT   0
`define TCU_DIV4_LAST     4'h3
`define TCU_DIV16_LAST    4'hf
`define TCU_INSTR_DIV     2'h3
`endif

// [common/tcu_pkg.sv]
// Types shared by the capture unit files
package tcu_pkg;
	typedef enum logic [3:0] {
		TCU_MODE_OFF   = 4'h0,
		TCU_MODE_FALL  = 4'h4,
		TCU_MODE_RISE  = 4'h5,
		TCU_MODE_RISE4 = 4'h6,
		TCU_MODE_RISE16 = 4'h7
	} tcu_mode_t;
	typedef struct packed {
		logic       fall;
		logic       rise;
	} tcu_edges_t;
endpackage

// [design/tcu_edge_sync.sv]
// Two-stage synchroniser and edge detector for the capture pin
module tcu_edge_sync (
	input  wire logic                SYS_CLK_I,
	input  wire logic                RESET_I,
	input  wire logic                pin_i,
	output tcu_pkg::tcu_edges_t      edges_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	// Stage one feeds stage two only
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign edges_o.rise = s2_q & ~s3_q;
	assign edges_o.fall = ~s2_q & s3_q;
endmodule

// [design/tcu_top.sv]
// Input-capture unit with free-running timebase, APB register slave
// ----------------------------------------------------------------
// Notes on behaviour
// - On a selected event copy the 16-bit timebase into the capture pair.
// - Mode picks falling, rising, every 4th or every 16th rising edge.
// - Each capture sets the flag; only a software write or reset clears it.
// - A new capture overwrites an unread one, no overrun flag.
// - Edge detector sees the port's driven level, not the pin, while the pin is an output.
// - Mode change may raise a false interrupt; software masks and clears.
// - Prescaler counter clears when off, not capturing, or reset.
// - Prescaler switch keeps the count; software clears control first.
// - Instruction-clocked timebase holds during sleep and resumes after.
// - Capture continues in sleep when timebase uses an external clock.
// - Interrupt reaches output only with global peripheral enable set too.
// ----------------------------------------------------------------
`include "tcu_defs.svh"
module tcu_top (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RESET_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// Capture pin and the port drive onto it
	input  wire logic        CAPTURE_PIN_I,
	input  wire logic        CAPTURE_PIN_OUT_I,
	input  wire logic        CAPTURE_PIN_OE_I,
	// Timebase clock and power state
	input  wire logic        EXT_CLK_I,
	input  wire logic        SLEEP_I,
	output logic             IRQ_O
);
	// ----------------------------------------------------------------
	// Pin sensing
	// ----------------------------------------------------------------
	logic                pin_level;
	logic                sleep_s1_q;
	logic                sleep_q;
	tcu_pkg::tcu_edges_t edges;
	tcu_pkg::tcu_edges_t ext_edges;

	// Own drive seen on the pin, so a port write can capture
	// Trade-off: while driven, the outside level is ignored
	assign pin_level = CAPTURE_PIN_OE_I ? CAPTURE_PIN_OUT_I : CAPTURE_PIN_I;

	tcu_edge_sync u_pin_sync (
		.SYS_CLK_I (SYS_CLK_I),
		.RESET_I   (RESET_I),
		.pin_i     (pin_level),
		.edges_o   (edges)
	);

	// Outside timebase clock is one more pin; it must stay below a
	// quarter of the core clock so that no edge slips between samples
	tcu_edge_sync u_ext_sync (
		.SYS_CLK_I (SYS_CLK_I),
		.RESET_I   (RESET_I),
		.pin_i     (EXT_CLK_I),
		.edges_o   (ext_edges)
	);

	// Sleep level arrives from another domain: two flops as well
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			sleep_s1_q <= 1'b0;
			sleep_q    <= 1'b0;
		end else begin
			sleep_s1_q <= SLEEP_I;
			sleep_q    <= sleep_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic       wr_en;
	logic       rd_setup;
	logic       rd_hit;
	logic       wr_ctrl;
	logic       wr_tb_ctrl;
	logic       wr_irq_en;
	logic       wr_global;
	logic       wr_irq_clr;
	logic       wr_tb_lo;
	logic       wr_tb_hi;
	logic [31:0] rd_word;
	logic [7:0] ctrl_q;
	logic [7:0] tb_ctrl_q;
	logic       irq_en_q;
	logic       global_en_q;
	logic       flag_q;
	logic [15:0] capt_q;
	logic [15:0] tb_q;
	tcu_pkg::tcu_mode_t mode;

	assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd_setup  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~rd_hit;
	assign mode = tcu_pkg::tcu_mode_t'(
		ctrl_q[`TCU_MODE_MSB:`TCU_MODE_LSB]);

	// One strobe per writable register; a write lands at the access edge
	assign wr_ctrl    = wr_en & (PADDR_I == `TCU_OFF_CTRL);
	assign wr_tb_ctrl = wr_en & (PADDR_I == `TCU_OFF_TB_CTRL);
	assign wr_irq_en  = wr_en & (PADDR_I == `TCU_OFF_IRQ_EN);
	assign wr_global  = wr_en & (PADDR_I == `TCU_OFF_GLOBAL);
	assign wr_irq_clr = wr_en & (PADDR_I == `TCU_OFF_IRQ_CLR);
	assign wr_tb_lo   = wr_en & (PADDR_I == `TCU_OFF_TB_LO);
	assign wr_tb_hi   = wr_en & (PADDR_I == `TCU_OFF_TB_HI);

	always_comb begin
		rd_hit = 1'b1;
		unique case (PADDR_I)
			`TCU_OFF_CTRL,
			`TCU_OFF_CAPT_LO,
			`TCU_OFF_CAPT_HI,
			`TCU_OFF_TB_LO,
			`TCU_OFF_TB_HI,
			`TCU_OFF_TB_CTRL,
			`TCU_OFF_STATUS,
			`TCU_OFF_IRQ_EN,
			`TCU_OFF_IRQ_CLR,
			`TCU_OFF_GLOBAL:  rd_hit = 1'b1;
			default: rd_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Register read-back
	// ----------------------------------------------------------------
	// Unmapped and write-only words read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (PADDR_I)
			`TCU_OFF_CTRL:    rd_word = {24'h00_0000, ctrl_q};
			`TCU_OFF_CAPT_LO: rd_word = {24'h00_0000, capt_q[7:0]};
			`TCU_OFF_CAPT_HI: rd_word = {24'h00_0000, capt_q[15:8]};
			`TCU_OFF_TB_LO:   rd_word = {24'h00_0000, tb_q[7:0]};
			`TCU_OFF_TB_HI:   rd_word = {24'h00_0000, tb_q[15:8]};
			`TCU_OFF_TB_CTRL: rd_word = {24'h00_0000, tb_ctrl_q};
			`TCU_OFF_STATUS:  rd_word = {31'h0, flag_q};
			`TCU_OFF_IRQ_EN:  rd_word = {31'h0, irq_en_q};
			`TCU_OFF_GLOBAL:  rd_word = {31'h0, global_en_q};
			default:          rd_word = 32'h0000_0000;
		endcase
	end

	// Latched in the setup phase, so the word stands through access
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (rd_setup) begin
			PRDATA_O <= rd_word;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ctrl_q <= `TCU_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= PWDATA_I[7:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			tb_ctrl_q <= `TCU_TB_CTRL_RESET;
		end else if (wr_tb_ctrl) begin
			tb_ctrl_q <= PWDATA_I[7:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			irq_en_q <= 1'b0;
		end else if (wr_irq_en) begin
			irq_en_q <= PWDATA_I[0];
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			global_en_q <= 1'b0;
		end else if (wr_global) begin
			global_en_q <= PWDATA_I[0];
		end
	end

	// ----------------------------------------------------------------
	// Timebase
	// ----------------------------------------------------------------
	logic [1:0] instr_div_q;
	logic       tb_tick;
	logic       tb_on;
	logic       tb_ext;

	assign tb_on  = tb_ctrl_q[`TCU_TB_ON_BIT];
	assign tb_ext = tb_ctrl_q[`TCU_TB_SRC_BIT];

	// Free-running quarter-rate divider stands in for the instruction clock
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			instr_div_q <= 2'h0;
		end else begin
			instr_div_q <= instr_div_q + 2'h1;
		end
	end

	// Synchronised external edges only; no asynchronous counting mode
	always_comb begin
		if (tb_ext) begin
			tb_tick = ext_edges.rise;
		end else begin
			tb_tick = (instr_div_q == `TCU_INSTR_DIV) & ~sleep_q;
		end
	end

	// A load beats a tick in the same cycle; halves are not latched
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			tb_q <= 16'h0000;
		end else if (wr_tb_lo) begin
			tb_q[7:0] <= PWDATA_I[7:0];
		end else if (wr_tb_hi) begin
			tb_q[15:8] <= PWDATA_I[7:0];
		end else if (tb_on & tb_tick) begin
			tb_q <= tb_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Event selection and prescaler
	// ----------------------------------------------------------------
	logic [3:0] pre_q;
	logic       capturing;
	logic       capt_evt;

	// Any code outside the four capture modes leaves the unit off
	assign capturing = (mode == tcu_pkg::TCU_MODE_FALL) |
		(mode == tcu_pkg::TCU_MODE_RISE) |
		(mode == tcu_pkg::TCU_MODE_RISE4) |
		(mode == tcu_pkg::TCU_MODE_RISE16);

	// Divided modes fire on the terminal count, then restart
	always_comb begin
		unique case (mode)
			tcu_pkg::TCU_MODE_FALL:   capt_evt = edges.fall;
			tcu_pkg::TCU_MODE_RISE:   capt_evt = edges.rise;
			tcu_pkg::TCU_MODE_RISE4:
				capt_evt = edges.rise & (pre_q >= `TCU_DIV4_LAST);
			tcu_pkg::TCU_MODE_RISE16:
				capt_evt = edges.rise & (pre_q >= `TCU_DIV16_LAST);
			default:                  capt_evt = 1'b0;
		endcase
	end

	// Count survives a direct prescaler switch; clear ctrl first
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			pre_q <= 4'h0;
		end else if (~capturing) begin
			pre_q <= 4'h0;
		end else if (capt_evt) begin
			pre_q <= 4'h0;
		end else if (edges.rise) begin
			pre_q <= pre_q + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Capture register and flag
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			capt_q <= 16'h0000;
		end else if (capt_evt) begin
			// Count as it stands before this edge's tick
			capt_q <= tb_q;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			flag_q <= 1'b0;
		end else if (capt_evt) begin
			flag_q <= 1'b1;
		end else if (wr_irq_clr & PWDATA_I[`TCU_ST_CAPT_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	// Level output; stays up until software clears the flag or clears irq_en_q or global_en_q
	assign IRQ_O = flag_q & irq_en_q & global_en_q;
endmodule

// [tb/tcu_assertions.sv]
// Port checker for the capture unit
module tcu_assertions (
	input wire logic        SYS_CLK_I,
	input wire logic        RESET_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        CAPTURE_PIN_I,
	input wire logic        CAPTURE_PIN_OUT_I,
	input wire logic        CAPTURE_PIN_OE_I,
	input wire logic        IRQ_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);
	logic       wr;
	logic       pin;
	logic       en_q;
	logic       gl_q;
	logic [3:0] md_q;
	assign wr = PSEL_I && PENABLE_I && PWRITE_I;
	// Driven level wins, so port writes count as edges
	assign pin = CAPTURE_PIN_OE_I ? CAPTURE_PIN_OUT_I : CAPTURE_PIN_I;
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			en_q <= 1'h0;
			gl_q <= 1'h0;
			md_q <= 4'h0;
		end else if (wr) begin
			if (PADDR_I == 12'h01c) en_q <= PWDATA_I[0];
			if (PADDR_I == 12'h024) gl_q <= PWDATA_I[0];
			if (PADDR_I == 12'h000) md_q <= PWDATA_I[3:0];
		end
	end
	// ------------------------------
	// Properties
	// ------------------------------
	AST_READY: assert property (PSEL_I |-> PREADY_O)
		else $error("pready low");
	AST_SLVERR: assert property (PSEL_I && PENABLE_I && PADDR_I > 12'h024
		|-> PSLVERR_O) else $error("unmapped access not refused");
	AST_NOERR: assert property (PSEL_I && PENABLE_I && PADDR_I <= 12'h024
		&& PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O) else $error("false pslverr");
	AST_STICKY: assert property (IRQ_O && !wr |=> IRQ_O)
		else $error("irq dropped without a write");
	AST_GLOBAL: assert property (!gl_q |-> !IRQ_O)
		else $error("irq without global enable");
	AST_ENABLE: assert property (!en_q |-> !IRQ_O)
		else $error("irq without unit enable");
	AST_RISE: assert property (md_q == 4'h5 && en_q && gl_q && $rose(pin)
		|-> ##[1:5] IRQ_O) else $error("rising edge not captured");
	AST_FALL: assert property (md_q == 4'h4 && en_q && gl_q && $fell(pin)
		|-> ##[1:5] IRQ_O) else $error("falling edge not captured");
endmodule
bind tcu_top tcu_assertions chk_u (.SYS_CLK_I, .RESET_I, .PSEL_I,
	.PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .PSLVERR_O,
	.CAPTURE_PIN_I, .CAPTURE_PIN_OUT_I, .CAPTURE_PIN_OE_I, .IRQ_O);

// [tb/tcu_evt_src.sv]
// Behavioural event source on the capture pin
module tcu_evt_src (
	input  wire logic SYS_CLK_I,
	output logic      pin_o,
	output logic      ext_clk_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// 10 MHz, well under a quarter of the core clock
	initial begin
		pin_o = 1'h0;
		ext_clk_o = 1'h0;
		forever #50 ext_clk_o = ~ext_clk_o;
	end
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge SYS_CLK_I) pin_o <= 1'h1;
			repeat (6) @(posedge SYS_CLK_I);
			pin_o <= 1'h0;
			repeat (6) @(posedge SYS_CLK_I);
		end
	endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the capture unit
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, s;
	logic        pin, ext, out, oe, sleep, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, h;
	int          fail_count = 0;
	int          n_checks = 0;
	tcu_top dut_u (.SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .CAPTURE_PIN_I(pin), .CAPTURE_PIN_OUT_I(out),
		.CAPTURE_PIN_OE_I(oe), .EXT_CLK_I(ext), .SLEEP_I(sleep),
		.IRQ_O(irq));
	tcu_evt_src src_u (.SYS_CLK_I(clk), .pin_o(pin), .ext_clk_o(ext));
	// ------------------------------
	// Bus and check helpers
	// ------------------------------
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		s = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rdc(input string n, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(n, e, r);
	endtask
	task automatic irqc(input string n, input logic e);
		@(negedge clk);
		chk(n, {31'h0, e}, {31'h0, irq});
		@(posedge clk);
	endtask
	task automatic arm(input logic [31:0] m);
		wr(12'h000, 32'h0);
		wr(12'h000, m);
		wr(12'h020, 32'h1);
	endtask
	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_regs();
		rdc("ctrl", 12'h000, 32'h0);
		rdc("status", 12'h018, 32'h0);
		rdc("irq clear", 12'h020, 32'h0);
		rdc("unmapped", 12'h028, 32'h0);
		chk("slverr", 32'h1, {31'h0, s});
		$display("test regs done");
	endtask
	task automatic t_modes();
		int need [4] = '{1, 4, 16, 1};
		logic [3:0] md [4] = '{4'h5, 4'h6, 4'h7, 4'h4};
		wr(12'h01c, 32'h1);
		wr(12'h024, 32'h1);
		wr(12'h014, 32'h1);
		for (int i = 0; i < 4; i++) begin
			arm({28'h0, md[i]});
			src_u.pulse(need[i] - 1);
			rdc("early flag", 12'h018, 32'h0);
			src_u.pulse(1);
			rdc("flag", 12'h018, 32'h1);
			irqc("irq", 1'h1);
		end
		arm(32'h6);
		src_u.pulse(2);
		arm(32'h6);
		src_u.pulse(3);
		rdc("prescaler cleared", 12'h018, 32'h0);
		$display("test modes done");
	endtask
	task automatic t_capt();
		wr(12'h014, 32'h0);
		wr(12'h00c, 32'h12);
		wr(12'h010, 32'h34);
		arm(32'h5);
		src_u.pulse(1);
		rdc("capt lo", 12'h004, 32'h12);
		rdc("capt hi", 12'h008, 32'h34);
		wr(12'h00c, 32'h78);
		wr(12'h010, 32'h56);
		src_u.pulse(1);
		rdc("capt lo new", 12'h004, 32'h78);
		rdc("capt hi new", 12'h008, 32'h56);
		$display("test capture done");
	endtask
	task automatic t_irq();
		wr(12'h024, 32'h0);
		irqc("no global", 1'h0);
		wr(12'h024, 32'h1);
		irqc("irq on", 1'h1);
		wr(12'h01c, 32'h0);
		irqc("masked", 1'h0);
		wr(12'h01c, 32'h1);
		rdc("sticky", 12'h018, 32'h1);
		wr(12'h020, 32'h1);
		rdc("cleared", 12'h018, 32'h0);
		irqc("irq off", 1'h0);
		$display("test irq done");
	endtask
	task automatic t_sleep();
		wr(12'h014, 32'h1);
		sleep <= 1'h1;
		repeat (8) @(posedge clk);
		apb(1'h0, 12'h00c, 32'h0);
		h = r;
		repeat (40) @(posedge clk);
		rdc("held count", 12'h00c, h);
		sleep <= 1'h0;
		repeat (40) @(posedge clk);
		apb(1'h0, 12'h00c, 32'h0);
		chk("resumed", 32'h1, {31'h0, r !== h});
		wr(12'h014, 32'h3);
		arm(32'h5);
		sleep <= 1'h1;
		src_u.pulse(1);
		rdc("sleep capture", 12'h018, 32'h1);
		sleep <= 1'h0;
		arm(32'h5);
		oe <= 1'h1;
		@(posedge clk) out <= 1'h1;
		repeat (8) @(posedge clk);
		rdc("driven pin capture", 12'h018, 32'h1);
		out <= 1'h0;
		oe <= 1'h0;
		$display("test sleep and pin drive done");
	endtask
	task automatic t_reset();
		wr(12'h000, 32'h7);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rdc("ctrl after reset", 12'h000, 32'h0);
		rdc("tb ctrl after reset", 12'h014, 32'h0);
		rdc("status after reset", 12'h018, 32'h0);
		irqc("irq after reset", 1'h0);
		$display("test reset done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		fail_count++;
		$display("timeout");
		summarize();
	end
	initial begin
		rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		out = 1'h0;
		oe = 1'h0;
		sleep = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_regs();
		t_modes();
		t_capt();
		t_irq();
		t_sleep();
		t_reset();
		summarize();
	end
endmodule
